/* bench/sftdr_sensor_model.sv */
// Sensor side model: free rate base clock and event pins
`timescale 1ns/1ps
module sftdr_sensor_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic fire,
  input wire logic [1:0] kind,
  output logic rateClk,
  output wire logic accelDrdy,
  output wire logic gyroDrdy,
  output wire logic stepDetected,
  output wire logic hubCycleDone
);
  logic [2:0] hold;
  logic [1:0] sel;
  // Rate base runs free, phase offset so its edges never sit on clk
  initial begin
    rateClk = 1'b0;
    #137;
    forever #400 rateClk = ~rateClk;
  end
  // Pins stay high four cycles; shorter pulses could slip past the synchroniser
  always @(posedge clk) begin
    if (!nrst) begin
      hold <= 3'h0;
    end else if (fire) begin
      hold <= 3'h4;
      sel <= kind;
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  // Kind 0 raises both data-ready pins, 2 a step, 3 a hub completion
  assign gyroDrdy = (hold != 3'h0) && (sel == 2'h0);
  assign accelDrdy = (hold != 3'h0) && (sel == 2'h0);
  assign stepDetected = (hold != 3'h0) && (sel == 2'h2);
  assign hubCycleDone = (hold != 3'h0) && (sel == 2'h3);
endmodule

/* bench/sftdr_tb_top.sv */
// Testbench: trigger select, decimation, pattern and readout against a queue model
`timescale 1ns/1ps
module sftdr_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fire = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] seed = 32'h00013523;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, rateClk, accelDrdy, gyroDrdy, stepDetected, hubCycleDone;
  logic [47:0] smp [4];
  logic [15:0] q [$];
  logic [15:0] lastWord;
  integer n_mismatch = 0;
  integer total_checks = 0;
  integer acc, popIdx, plen, i;
  integer dec [4];
  always #50 clk = ~clk;
  // Design with a short rate base so rate codes give periods of a few edges
  sftdr_top #(.BASE_TICKS(1024)) uut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rateClk, .accelDrdy, .gyroDrdy, .stepDetected, .hubCycleDone,
    .gyroSample(smp[0]), .accelSample(smp[1]), .set3Sample(smp[2]), .set4Sample(smp[3]));
  sftdr_sensor_model pm (.clk, .nrst, .fire, .kind, .rateClk, .accelDrdy, .gyroDrdy,
    .stepDetected, .hubCycleDone);
  ////////////////////////////////////////////////////////////////////////
  function automatic [31:0] lfsrNext(input [31:0] s);
    lfsrNext = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task stop_test;
    begin
      if (n_mismatch == 0 && total_checks > 0) begin
        $display("Result: passed");
      end else begin
        $display("Result: failed");
      end
      $finish;
    end
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    integer k;
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      @(posedge clk);
      while (pready !== 1'b1 && k < 50) begin
        k = k + 1;
        @(posedge clk);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      check(rd, exp);
    end
  endtask
  // Bypass first clears the queue, then the new setup is loaded
  task conf(input logic hub, input logic step, input logic [3:0] rate);
    integer e, s, m;
    begin
      apb(1'b1, 8'h0C, 32'h0);
      apb(1'b1, 8'h00, {31'h0, step});
      apb(1'b1, 8'h10, {31'h0, hub});
      apb(1'b1, 8'h04, dec[1] * 8 + dec[0]);
      apb(1'b1, 8'h08, dec[3] * 8 + dec[2]);
      rdchk(8'h04, dec[1] * 8 + dec[0]);
      rdchk(8'h08, dec[3] * 8 + dec[2]);
      // Sensor rates never change mid-run, so the fixed top rate is not forced
      apb(1'b1, 8'h0C, {25'h0, rate, 3'h1});
      q.delete();
      acc = 0;
      popIdx = 0;
      plen = 0;
      m = 1;
      for (s = 0; s < 4; s++) if (dec[s] > m) m = dec[s];
      for (e = 0; e < m; e++) for (s = 0; s < 4; s++) if (dec[s] != 0 && e % dec[s] == 0) plen += 3;
    end
  endtask
  // Fresh random samples, one event; the model stores due sets as X, Y, Z words
  task ev(input logic [1:0] k, input logic store);
    integer s;
    begin
      @(posedge clk);
      for (s = 0; s < 4; s++) begin
        seed = lfsrNext(seed);
        smp[s] <= {seed[15:0], lfsrNext(seed)};
        seed = lfsrNext(seed);
      end
      fire <= 1'b1;
      kind <= k;
      @(posedge clk);
      fire <= 1'b0;
      repeat (40) @(posedge clk);
      if (store) begin
        for (s = 0; s < 4; s++) begin
          if (dec[s] != 0 && acc % dec[s] == 0) begin
            q.push_back(smp[s][15:0]);
            q.push_back(smp[s][31:16]);
            q.push_back(smp[s][47:32]);
          end
        end
        acc = acc + 1;
      end
    end
  endtask
  // Empty the queue word by word, then read on while empty
  task drain;
    logic [15:0] w;
    begin
      rdchk(8'h14, q.size());
      rdchk(8'h18, 32'h0);
      // Setup stays untouched until the queue is empty
      while (q.size() > 0) begin
        rdchk(8'h1C, popIdx % plen);
        rdchk(8'h20, 32'h0);
        w = q.pop_front();
        rdchk(8'h24, {24'h0, w[7:0]});
        rdchk(8'h28, {24'h0, w[15:8]});
        lastWord = w;
        // Reads run far faster than events arrive, so nothing is lost
        popIdx = popIdx + 1;
      end
      rdchk(8'h18, 32'h10);
      rdchk(8'h24, {24'h0, lastWord[7:0]});
      rdchk(8'h28, {24'h0, lastWord[15:8]});
      rdchk(8'h14, 32'h0);
      rdchk(8'h1C, popIdx % plen);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (i = 0; i < 4; i++) smp[i] = 48'h0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i <= 32; i += 4) rdchk(i, (i == 24) ? 32'h10 : 32'h0);
    apb(1'b1, 8'h14, 32'hFF);
    rdchk(8'h14, 32'h0);
    apb(1'b0, 8'h2C, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b0, 8'h05, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    // Step trigger, factors 1, 2, off, 4: pattern of 21 words wraps
    dec = '{1, 2, 0, 4};
    conf(1'b0, 1'b1, 4'h0);
    repeat (5) ev(2'h2, 1'b1);
    drain;
    // Hub select wins over step select
    conf(1'b1, 1'b1, 4'h0);
    ev(2'h2, 1'b0);
    rdchk(8'h14, 32'h0);
    ev(2'h3, 1'b1);
    drain;
    // Data-ready trigger at equal rates; a second edge too soon is dropped
    dec = '{1, 1, 0, 0};
    conf(1'b0, 1'b0, 4'h7);
    // Rates equal and fixed, so no rate-change flow is needed
    repeat (200) @(posedge clk);
    ev(2'h0, 1'b1);
    ev(2'h0, 1'b0);
    repeat (200) @(posedge clk);
    ev(2'h0, 1'b1);
    drain;
    stop_test;
  end
  // Watchdog against a hung wait
  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch = n_mismatch + 1;
    stop_test;
  end
endmodule

/* bench/sftdr_top_chk.sv */
// Checker for the APB answers of the sample queue
`timescale 1ns/1ps
module sftdr_top_chk (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Decode of the setup cycle; a bad address is unmapped or unaligned
  wire setup = psel && !penable;
  wire rdSetup = setup && !pwrite;
  wire bad = (paddr > 8'h28) || (paddr[1:0] != 2'h0);
  ////////////////////////////////////////////////////////////////////////
  chk_always_ready: assert property (pready)
    else $error("pready low");
  chk_bad_refused: assert property (setup && bad |=> pslverr)
    else $error("bad address accepted");
  chk_bad_no_data: assert property (rdSetup && bad |=> prdata == 32'h0)
    else $error("bad address returned data");
  chk_good_accepted: assert property (setup && !bad |=> !pslverr)
    else $error("mapped address refused");
  chk_count_width: assert property (rdSetup && paddr == 8'h18 |=> prdata[31:6] == 26'h0)
    else $error("count high part too wide");
  chk_pattern_width: assert property (rdSetup && paddr == 8'h20 |=> prdata[31:2] == 30'h0)
    else $error("pattern high part too wide");
  chk_low_byte: assert property (rdSetup && paddr == 8'h24 |=> prdata[31:8] == 24'h0)
    else $error("low output wider than a byte");
  chk_high_byte: assert property (rdSetup && paddr == 8'h28 |=> prdata[31:8] == 24'h0)
    else $error("high output wider than a byte");
  chk_data_stands: assert property (psel && penable |=> $stable(prdata))
    else $error("read data moved after access");
  // Main scenarios
  cov_pop: cover property (rdSetup && paddr == 8'h28);
  cov_refuse: cover property (setup && bad);
  cov_write: cover property (setup && pwrite);
endmodule
bind sftdr_top sftdr_top_chk chk (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr);

/* rtl/sftdr_decimator.v */
// Per data set decimation counter, stepped once per accepted queue trigger (write side) or per step read out or skipped (read side)
`timescale 1ns/1ps
module sftdr_decimator (
  input wire clk,
  input wire nrst,
  input wire clear,
  input wire step,
  input wire [2:0] code,
  output wire due,
  output wire last
);
  reg [4:0] cnt;
  reg [5:0] factor;
  wire enabled;
  wire [4:0] top;

  // Code to factor; code zero keeps the set out of the queue
  always @* begin
    case (code)
      3'h1: factor = 6'h01;
      3'h2: factor = 6'h02;
      3'h3: factor = 6'h03;
      3'h4: factor = 6'h04;
      3'h5: factor = 6'h08;
      3'h6: factor = 6'h10;
      3'h7: factor = 6'h20;
      default: factor = 6'h00;
    endcase
  end

  assign enabled = (factor != 6'h00);
  assign top = factor[4:0] - 5'h01;
  // Count zero is the stored step, so the first step after a clear stores every enabled set
  assign due = enabled & (cnt == 5'h00);
  assign last = ~enabled | (cnt == top);

  // Modulo-factor counter
  always @(posedge clk) begin
    if (!nrst || clear) begin
      cnt <= 5'h00;
    end else if (step) begin
      cnt <= last ? 5'h00 : cnt + 5'h01;
    end
  end
endmodule

/* rtl/sftdr_defines.vh */
// Register map, field positions, reset values and timing counts of the sample queue
`ifndef SFTDR_DEFINES_VH
`define SFTDR_DEFINES_VH

// Register byte addresses on the APB port
`define SFTDR_A_CTRL2 8'h00
`define SFTDR_A_CTRL3 8'h04
`define SFTDR_A_CTRL4 8'h08
`define SFTDR_A_CTRL5 8'h0C
`define SFTDR_A_HUBCFG 8'h10
`define SFTDR_A_STATE1 8'h14
`define SFTDR_A_STATE2 8'h18
`define SFTDR_A_STATE3 8'h1C
`define SFTDR_A_STATE4 8'h20
`define SFTDR_A_OUTLO 8'h24
`define SFTDR_A_OUTHI 8'h28

// Field positions
`define SFTDR_STEP_SEL_BIT 0
`define SFTDR_HUB_SEL_BIT 0
`define SFTDR_GDEC_LSB 0
`define SFTDR_ADEC_LSB 3
`define SFTDR_S3DEC_LSB 0
`define SFTDR_S4DEC_LSB 3
`define SFTDR_MODE_LSB 0
`define SFTDR_QRATE_LSB 3
`define SFTDR_EMPTY_BIT 4
`define SFTDR_FULL_BIT 5

// Reset values and codes
`define SFTDR_RST_DEC 3'h0
`define SFTDR_RST_MODE 3'h0
`define SFTDR_RST_QRATE 4'h0
`define SFTDR_MODE_BYPASS 3'h0
`define SFTDR_QRATE_MAX 4'hA
`define SFTDR_FULL_COUNT 12'hFFF

// Timing: rate base sampled from the rate clock pin
`define SFTDR_RATE_CLK_NS 800
`define SFTDR_BASE_PERIOD_NS 80000000
`define SFTDR_BASE_TICKS (`SFTDR_BASE_PERIOD_NS / `SFTDR_RATE_CLK_NS)

`endif

/* rtl/sftdr_top.v */
// Sensor sample queue: trigger select, rate limit, decimation, storage and APB readout
`timescale 1ns/1ps
`include "sftdr_defines.vh"
module sftdr_top #(
  parameter BASE_TICKS = `SFTDR_BASE_TICKS
) (
  input wire clk,
  input wire nrst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire rateClk,
  input wire accelDrdy,
  input wire gyroDrdy,
  input wire stepDetected,
  input wire hubCycleDone,
  input wire [47:0] gyroSample,
  input wire [47:0] accelSample,
  input wire [47:0] set3Sample,
  input wire [47:0] set4Sample
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Lowest set at or above 'from' whose bit is set; msb flags a find
  function [2:0] firstDue;
    input [3:0] mask;
    input [2:0] from;
    integer i;
    begin
      firstDue = 3'h0;
      for (i = 3; i >= 0; i = i - 1) begin
        if (mask[i] && (i >= from)) begin
          firstDue = {1'b1, i[1:0]};
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  reg stepTriggerSelect;
  reg hubTriggerSelect;
  reg [2:0] gyroDecimCode;
  reg [2:0] accelDecimCode;
  reg [2:0] set3DecimCode;
  reg [2:0] set4DecimCode;
  reg [2:0] queueMode;
  reg [3:0] queueRateCode;

  wire setup;
  wire access;
  wire bypass;
  reg [31:0] next_prdata;
  reg next_slverr;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1; // Zero wait state slave
  assign bypass = (queueMode == `SFTDR_MODE_BYPASS);

  // Register writes take effect at the access edge
  always @(posedge clk) begin
    if (!nrst) begin
      stepTriggerSelect <= 1'b0;
      hubTriggerSelect <= 1'b0;
      gyroDecimCode <= `SFTDR_RST_DEC;
      accelDecimCode <= `SFTDR_RST_DEC;
      set3DecimCode <= `SFTDR_RST_DEC;
      set4DecimCode <= `SFTDR_RST_DEC;
      queueMode <= `SFTDR_RST_MODE;
      queueRateCode <= `SFTDR_RST_QRATE;
    end else if (access && pwrite) begin
      case (paddr)
        `SFTDR_A_CTRL2: stepTriggerSelect <= pwdata[`SFTDR_STEP_SEL_BIT];
        `SFTDR_A_HUBCFG: hubTriggerSelect <= pwdata[`SFTDR_HUB_SEL_BIT];
        `SFTDR_A_CTRL3: begin
          gyroDecimCode <= pwdata[`SFTDR_GDEC_LSB +: 3];
          accelDecimCode <= pwdata[`SFTDR_ADEC_LSB +: 3];
        end
        `SFTDR_A_CTRL4: begin
          set3DecimCode <= pwdata[`SFTDR_S3DEC_LSB +: 3];
          set4DecimCode <= pwdata[`SFTDR_S4DEC_LSB +: 3];
        end
        `SFTDR_A_CTRL5: begin
          queueMode <= pwdata[`SFTDR_MODE_LSB +: 3];
          queueRateCode <= pwdata[`SFTDR_QRATE_LSB +: 4];
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 0 rate clock, 1 accel, 2 gyro, 3 step, 4 hub

  reg [4:0] syncA;
  reg [4:0] syncB;
  reg [4:0] syncPrev;
  wire [4:0] edges;

  // Two flops before any logic; only syncB feeds the edge detector
  always @(posedge clk) begin
    if (!nrst) begin
      syncA <= 5'h00;
      syncB <= 5'h00;
      syncPrev <= 5'h00;
    end else begin
      syncA <= {hubCycleDone, stepDetected, gyroDrdy, accelDrdy, rateClk};
      syncB <= syncA;
      syncPrev <= syncB;
    end
  end

  assign edges = syncB & ~syncPrev;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger selection and queue rate limiter

  reg [16:0] rateCnt;
  wire [3:0] rateCode;
  wire [16:0] ratePeriod;
  wire rateOk;
  wire trigger;
  wire accept;
  reg wrBusy;

  // Codes above the top rate run at the top rate
  assign rateCode = (queueRateCode > `SFTDR_QRATE_MAX) ? `SFTDR_QRATE_MAX : queueRateCode;
  assign ratePeriod = BASE_TICKS[16:0] >> (rateCode - 4'h1);
  // Data-ready arrives at the faster sensor rate; the limiter caps it at the queue rate
  assign rateOk = (queueRateCode != 4'h0) && (rateCnt >= ratePeriod);
  assign trigger = hubTriggerSelect ? edges[4] :
                   stepTriggerSelect ? edges[3] :
                   ((edges[1] | edges[2]) & rateOk);
  // Triggers during a write burst are dropped so both schedules stay in step
  assign accept = trigger & ~wrBusy & ~bypass;

  // Rate clock edges since the last stored data-ready trigger, saturating
  always @(posedge clk) begin
    if (!nrst) begin
      rateCnt <= 17'h00000;
    end else if (accept && !hubTriggerSelect && !stepTriggerSelect) begin
      rateCnt <= 17'h00000;
    end else if (edges[0] && (rateCnt < BASE_TICKS[16:0])) begin
      rateCnt <= rateCnt + 17'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decimators: write side and a read-side replica for the pattern index

  wire [3:0] wrDue;
  wire [3:0] rdDue;
  wire [3:0] rdLast;
  wire [11:0] decCodes;
  wire rdStep;
  genvar g;

  assign decCodes = {set4DecimCode, set3DecimCode, accelDecimCode, gyroDecimCode};

  generate
    for (g = 0; g < 4; g = g + 1) begin : dec
      // Write side decides which sets a trigger stores
      sftdr_decimator wrDec (
        .clk(clk),
        .nrst(nrst),
        .clear(bypass),
        .step(accept),
        .code(decCodes[3*g +: 3]),
        .due(wrDue[g]),
        .last()
      );
      // Read side replays the same schedule to know what comes out next
      sftdr_decimator rdDec (
        .clk(clk),
        .nrst(nrst),
        .clear(bypass),
        .step(rdStep),
        .code(decCodes[3*g +: 3]),
        .due(rdDue[g]),
        .last(rdLast[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Storage and pointers

  reg [15:0] mem [0:4095];
  reg [11:0] wrPtr;
  reg [11:0] rdPtr;
  reg [15:0] outWord;
  wire [11:0] storedWordCount;
  wire queueEmpty;
  wire queueFull;
  wire pop;
  wire [11:0] rdPtrNext;

  assign storedWordCount = wrPtr - rdPtr;
  assign queueEmpty = (storedWordCount == 12'h000);
  assign queueFull = (storedWordCount == `SFTDR_FULL_COUNT);
  // A read of the high byte completes the pair and pops the oldest word
  assign pop = access & ~pwrite & (paddr == `SFTDR_A_OUTHI) & ~queueEmpty & ~bypass;
  assign rdPtrNext = pop ? rdPtr + 12'h001 : rdPtr;

  ////////////////////////////////////////////////////////////////////////////
  // Write sequencer: three words per due set, sets in order one to four

  reg [191:0] snap;
  reg [3:0] wrMask;
  reg [1:0] wrSet;
  reg [1:0] wrAxis;
  wire [2:0] wrNext;
  wire [2:0] wrFirst;
  wire [15:0] wrWord;
  wire [7:0] wrBit;

  assign wrFirst = firstDue(wrDue, 3'h0);
  assign wrNext = firstDue(wrMask, {1'b0, wrSet} + 3'h1);
  // Sets sit 48 bits apart in the snapshot: set * 48 + axis * 16
  assign wrBit = {1'b0, wrSet, 5'h00} + {2'h0, wrSet, 4'h0} + {2'h0, wrAxis, 4'h0};
  assign wrWord = snap[wrBit +: 16];

  always @(posedge clk) begin
    if (!nrst || bypass) begin
      wrBusy <= 1'b0;
      wrMask <= 4'h0;
      wrSet <= 2'h0;
      wrAxis <= 2'h0;
      wrPtr <= 12'h000;
      snap <= 192'h0;
    end else if (accept) begin
      snap <= {set4Sample, set3Sample, accelSample, gyroSample};
      wrMask <= wrDue;
      wrSet <= wrFirst[1:0];
      wrAxis <= 2'h0;
      wrBusy <= wrFirst[2];
    end else if (wrBusy) begin
      // A full queue drops the word; alignment is lost, as with any overrun
      if (!queueFull) begin
        wrPtr <= wrPtr + 12'h001;
      end
      if (wrAxis != 2'h2) begin
        wrAxis <= wrAxis + 2'h1;
      end else begin
        wrAxis <= 2'h0;
        wrSet <= wrNext[1:0];
        wrBusy <= wrNext[2];
      end
    end
  end

  // Memory write port
  always @(posedge clk) begin
    if (wrBusy && !queueFull && !bypass) begin
      mem[wrPtr] <= wrWord;
    end
  end

  // Output word follows the oldest entry; empty holds the last one read
  always @(posedge clk) begin
    if (!nrst) begin
      outWord <= 16'h0000;
    end else if (wrPtr != rdPtrNext) begin
      outWord <= mem[rdPtrNext];
    end
  end

  always @(posedge clk) begin
    if (!nrst || bypass) begin
      rdPtr <= 12'h000;
    end else begin
      rdPtr <= rdPtrNext;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read position and pattern index

  reg [1:0] rdSet;
  reg [1:0] rdAxis;
  reg rdSeek;
  reg [9:0] patternIndex;
  wire [2:0] rdNext;
  wire [2:0] rdFirst;
  wire endOfStep;

  assign rdNext = firstDue(rdDue, {1'b0, rdSet} + 3'h1);
  assign rdFirst = firstDue(rdDue, 3'h0);
  assign endOfStep = pop & (rdAxis == 2'h2) & ~rdNext[2];
  assign rdStep = endOfStep | (rdSeek & ~rdFirst[2]);

  // Seek picks the first due set of a step; empty steps are skipped
  always @(posedge clk) begin
    if (!nrst || bypass) begin
      rdSet <= 2'h0;
      rdAxis <= 2'h0;
      rdSeek <= 1'b1;
      patternIndex <= 10'h000;
    end else if (rdSeek) begin
      if (rdFirst[2]) begin
        rdSet <= rdFirst[1:0];
        rdSeek <= 1'b0;
      end else if (&rdLast) begin
        patternIndex <= 10'h000;
      end
    end else if (pop) begin
      if (rdAxis != 2'h2) begin
        rdAxis <= rdAxis + 2'h1;
        patternIndex <= patternIndex + 10'h001;
      end else if (rdNext[2]) begin
        rdAxis <= 2'h0;
        rdSet <= rdNext[1:0];
        patternIndex <= patternIndex + 10'h001;
      end else begin
        rdAxis <= 2'h0;
        rdSeek <= 1'b1;
        // Pattern repeats when every set's counter wraps together
        patternIndex <= (&rdLast) ? 10'h000 : patternIndex + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB read data, captured in the setup cycle

  always @* begin
    next_prdata = 32'h00000000;
    next_slverr = 1'b0;
    case (paddr)
      `SFTDR_A_CTRL2: next_prdata[`SFTDR_STEP_SEL_BIT] = stepTriggerSelect;
      `SFTDR_A_HUBCFG: next_prdata[`SFTDR_HUB_SEL_BIT] = hubTriggerSelect;
      `SFTDR_A_CTRL3: begin
        next_prdata[`SFTDR_GDEC_LSB +: 3] = gyroDecimCode;
        next_prdata[`SFTDR_ADEC_LSB +: 3] = accelDecimCode;
      end
      `SFTDR_A_CTRL4: begin
        next_prdata[`SFTDR_S3DEC_LSB +: 3] = set3DecimCode;
        next_prdata[`SFTDR_S4DEC_LSB +: 3] = set4DecimCode;
      end
      `SFTDR_A_CTRL5: begin
        next_prdata[`SFTDR_MODE_LSB +: 3] = queueMode;
        next_prdata[`SFTDR_QRATE_LSB +: 4] = queueRateCode;
      end
      `SFTDR_A_STATE1: next_prdata[7:0] = storedWordCount[7:0];
      `SFTDR_A_STATE2: begin
        next_prdata[3:0] = storedWordCount[11:8];
        next_prdata[`SFTDR_EMPTY_BIT] = queueEmpty;
        next_prdata[`SFTDR_FULL_BIT] = queueFull;
      end
      `SFTDR_A_STATE3: next_prdata[7:0] = patternIndex[7:0];
      `SFTDR_A_STATE4: next_prdata[1:0] = patternIndex[9:8];
      `SFTDR_A_OUTLO: next_prdata[7:0] = outWord[7:0];
      // Burst rounding: software alternates low/high and each high read pops
      `SFTDR_A_OUTHI: next_prdata[7:0] = outWord[15:8];
      default: next_slverr = 1'b1;
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : next_prdata;
      pslverr <= next_slverr;
    end
  end
endmodule
